// ### ier_consts.svh
// Offsets, field positions, masks and reset values of the enable register bank
`ifndef IER_CONSTS_SVH
`define IER_CONSTS_SVH

`define IER_ENABLE1_OFFSET         8'h00
`define IER_ENABLE2_OFFSET         8'h04
`define IER_ENABLE3_OFFSET         8'h08
`define IER_ENABLE4_OFFSET         8'h0C
`define IER_FLAG1_OFFSET           8'h10
`define IER_FLAG2_OFFSET           8'h14
`define IER_FLAG3_OFFSET           8'h18
`define IER_FLAG4_OFFSET           8'h1C

`define IER_MASK1                  16'hF85F
`define IER_MASK2                  16'h0200
`define IER_MASK3                  16'h4006
`define IER_MASK4                  16'hE106
`define IER_RESET_VALUE            16'h0000

`define IER_SERIAL2_TX_BIT         15
`define IER_SERIAL2_RX_BIT         14
`define IER_EXT_PIN2_BIT           13
`define IER_CAPCMP4_TIMER_BIT      12
`define IER_CAPCMP3_TIMER_BIT      11
`define IER_CAPCMP5_EVENT_BIT      6
`define IER_EXT_PIN1_BIT           4
`define IER_CHANGE_NOTIFY_BIT      3
`define IER_COMPARATOR_BIT         2
`define IER_SYNC1_COLLISION_BIT    1
`define IER_SYNC1_EVENT_BIT        0
`define IER_CAPCMP5_TIMER_BIT      9
`define IER_CALENDAR_CLOCK_BIT     14
`define IER_SYNC2_COLLISION_BIT    2
`define IER_SYNC2_EVENT_BIT        1
`define IER_DAC_TWO_BIT            15
`define IER_DAC_ONE_BIT            14
`define IER_CHARGE_TIME_BIT        13
`define IER_VOLTAGE_DETECT_BIT     8
`define IER_SERIAL2_ERROR_BIT      2
`define IER_SERIAL1_ERROR_BIT      1

`endif

// ### ier_pkg.sv
// Types shared by the enable register bank
package ier_pkg;
    typedef logic [15:0] ier_word_t;
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_READ  = 3'b100
    } ier_acc_t;
endpackage

// ### ier_reg_if.sv
// Write and read strobes from the bus front end to the register banks
`timescale 1ns/100ps
interface ier_reg_if;
    logic [3:0]         wrEnable;
    logic [3:0]         wrFlag;
    ier_pkg::ier_word_t wrData;
    logic               rdAccept;
    logic               rdPend;
    logic [2:0]         rdIdx;
    logic               rdMapped;

    modport bus (
        output wrEnable,
        output wrFlag,
        output wrData,
        output rdAccept,
        output rdPend,
        output rdIdx,
        output rdMapped
    );
    modport bank (
        input  wrEnable,
        input  wrFlag,
        input  wrData,
        input  rdAccept,
        input  rdPend,
        input  rdIdx,
        input  rdMapped
    );
endinterface

// ### ier_bus_front.sv
// AHB-Lite address phase capture and data phase strobes
`timescale 1ns/100ps
`include "ier_consts.svh"
module ier_bus_front (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    ier_reg_if.bus           regPort
);
    ier_pkg::ier_acc_t accState_ff;
    ier_pkg::ier_acc_t nxt_accState;
    logic [2:0]        idx_ff;
    logic              mapped_ff;

    wire accept    = hsel & htrans[1] & hready;
    wire addrInMap = (haddr[31:5] == 27'h0000000);
    wire [3:0] oneHot = 4'h1 << idx_ff[1:0];
    wire doWrite   = (accState_ff == ier_pkg::ACC_WRITE) & mapped_ff;

    always_comb begin
        nxt_accState = ier_pkg::ACC_IDLE;
        case (accState_ff)
            ier_pkg::ACC_IDLE,
            ier_pkg::ACC_WRITE: begin
                if (accept) begin
                    nxt_accState = hwrite ? ier_pkg::ACC_WRITE : ier_pkg::ACC_READ;
                end
            end
            // Read holds one wait state; no new address phase is taken meanwhile
            ier_pkg::ACC_READ: nxt_accState = ier_pkg::ACC_IDLE;
            default:           nxt_accState = ier_pkg::ACC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accState_ff <= ier_pkg::ACC_IDLE;
            idx_ff      <= 3'h0;
            mapped_ff   <= 1'b0;
        end else begin
            accState_ff <= nxt_accState;
            if (accept) begin
                idx_ff    <= haddr[4:2];
                mapped_ff <= addrInMap;
            end
        end
    end

    assign regPort.wrEnable = (doWrite & ~idx_ff[2]) ? oneHot : 4'h0;
    assign regPort.wrFlag   = (doWrite &  idx_ff[2]) ? oneHot : 4'h0;
    assign regPort.wrData   = hwdata[15:0];
    assign regPort.rdAccept = accept & ~hwrite & (accState_ff != ier_pkg::ACC_READ);
    assign regPort.rdPend   = (accState_ff == ier_pkg::ACC_READ);
    assign regPort.rdIdx    = idx_ff;
    assign regPort.rdMapped = mapped_ff;
endmodule

// ### ier_enable_reg.sv
// One 16-bit enable word with its flag word and gated requests
`timescale 1ns/100ps
`include "ier_consts.svh"
module ier_enable_reg #(
    parameter int                 IDX  = 0,
    parameter ier_pkg::ier_word_t IMPL = 16'hFFFF
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    ier_reg_if.bank                 regPort,
    input  wire ier_pkg::ier_word_t srcEvent,
    output ier_pkg::ier_word_t      enable_ff,
    output ier_pkg::ier_word_t      flag_ff,
    output ier_pkg::ier_word_t      request_ff
);
    ier_pkg::ier_word_t nxt_enable;
    ier_pkg::ier_word_t nxt_flag;

    wire wrEn = regPort.wrEnable[IDX];
    wire wrFl = regPort.wrFlag[IDX];

    // Unused positions never store a one
    assign nxt_enable = wrEn ? (regPort.wrData & IMPL) : enable_ff;
    // Flags record regardless of enable; a source event beats a clearing write
    assign nxt_flag   = ((wrFl ? regPort.wrData : flag_ff) | srcEvent) & IMPL;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_ff  <= `IER_RESET_VALUE;
            flag_ff    <= `IER_RESET_VALUE;
            request_ff <= `IER_RESET_VALUE;
        end else begin
            enable_ff  <= nxt_enable;
            flag_ff    <= nxt_flag;
            request_ff <= flag_ff & enable_ff;
        end
    end
endmodule

// ### ier_enable_top.sv
// Interrupt enable registers one to four with AHB-Lite access and request gating
`timescale 1ns/100ps
`include "ier_consts.svh"
module ier_enable_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        serial2TxEvent,
    input  wire logic        serial2RxEvent,
    input  wire logic        extPin2Event,
    input  wire logic        capcmp4TimerEvent,
    input  wire logic        capcmp3TimerEvent,
    input  wire logic        capcmp5EventEvent,
    input  wire logic        extPin1Event,
    input  wire logic        changeNotifyEvent,
    input  wire logic        comparatorEvent,
    input  wire logic        syncPort1CollisionEvent,
    input  wire logic        syncPort1EventEvent,
    input  wire logic        capcmp5TimerEvent,
    input  wire logic        calendarClockEvent,
    input  wire logic        syncPort2CollisionEvent,
    input  wire logic        syncPort2EventEvent,
    input  wire logic        dacTwoEvent,
    input  wire logic        dacOneEvent,
    input  wire logic        chargeTimeUnitEvent,
    input  wire logic        voltageDetectEvent,
    input  wire logic        serial2ErrorEvent,
    input  wire logic        serial1ErrorEvent,
    output logic             serial2TxIrqReq,
    output logic             serial2RxIrqReq,
    output logic             extPin2IrqReq,
    output logic             capcmp4TimerIrqReq,
    output logic             capcmp3TimerIrqReq,
    output logic             capcmp5EventIrqReq,
    output logic             extPin1IrqReq,
    output logic             changeNotifyIrqReq,
    output logic             comparatorIrqReq,
    output logic             syncPort1CollisionIrqReq,
    output logic             syncPort1EventIrqReq,
    output logic             capcmp5TimerIrqReq,
    output logic             calendarClockIrqReq,
    output logic             syncPort2CollisionIrqReq,
    output logic             syncPort2EventIrqReq,
    output logic             dacTwoIrqReq,
    output logic             dacOneIrqReq,
    output logic             chargeTimeUnitIrqReq,
    output logic             voltageDetectIrqReq,
    output logic             serial2ErrorIrqReq,
    output logic             serial1ErrorIrqReq
);
    localparam ier_pkg::ier_word_t IMPL_MASK [4] = '{`IER_MASK1, `IER_MASK2, `IER_MASK3, `IER_MASK4};

    ier_reg_if regBus ();

    ier_pkg::ier_word_t srcWord [4];
    ier_pkg::ier_word_t enWord  [4];
    ier_pkg::ier_word_t flWord  [4];
    ier_pkg::ier_word_t reqWord [4];
    logic [31:0]        hrdata_ff;
    logic               hreadyout_ff;
    logic               hresp_ff;
    ier_pkg::ier_word_t selWord;
    logic [31:0]        nxt_hrdata;

    ier_bus_front u_front (
        .sys_clk (sys_clk),
        .rst     (rst),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .hwdata  (hwdata),
        .regPort (regBus.bus)
    );

    // Sources mapped onto their enable positions
    always_comb begin
        srcWord[0] = 16'h0000;
        srcWord[1] = 16'h0000;
        srcWord[2] = 16'h0000;
        srcWord[3] = 16'h0000;
        srcWord[0][`IER_SERIAL2_TX_BIT]      = serial2TxEvent;
        srcWord[0][`IER_SERIAL2_RX_BIT]      = serial2RxEvent;
        srcWord[0][`IER_EXT_PIN2_BIT]        = extPin2Event;
        srcWord[0][`IER_CAPCMP4_TIMER_BIT]   = capcmp4TimerEvent;
        srcWord[0][`IER_CAPCMP3_TIMER_BIT]   = capcmp3TimerEvent;
        srcWord[0][`IER_CAPCMP5_EVENT_BIT]   = capcmp5EventEvent;
        srcWord[0][`IER_EXT_PIN1_BIT]        = extPin1Event;
        srcWord[0][`IER_CHANGE_NOTIFY_BIT]   = changeNotifyEvent;
        srcWord[0][`IER_COMPARATOR_BIT]      = comparatorEvent;
        srcWord[0][`IER_SYNC1_COLLISION_BIT] = syncPort1CollisionEvent;
        srcWord[0][`IER_SYNC1_EVENT_BIT]     = syncPort1EventEvent;
        srcWord[1][`IER_CAPCMP5_TIMER_BIT]   = capcmp5TimerEvent;
        srcWord[2][`IER_CALENDAR_CLOCK_BIT]  = calendarClockEvent;
        srcWord[2][`IER_SYNC2_COLLISION_BIT] = syncPort2CollisionEvent;
        srcWord[2][`IER_SYNC2_EVENT_BIT]     = syncPort2EventEvent;
        srcWord[3][`IER_DAC_TWO_BIT]         = dacTwoEvent;
        srcWord[3][`IER_DAC_ONE_BIT]         = dacOneEvent;
        srcWord[3][`IER_CHARGE_TIME_BIT]     = chargeTimeUnitEvent;
        srcWord[3][`IER_VOLTAGE_DETECT_BIT]  = voltageDetectEvent;
        srcWord[3][`IER_SERIAL2_ERROR_BIT]   = serial2ErrorEvent;
        srcWord[3][`IER_SERIAL1_ERROR_BIT]   = serial1ErrorEvent;
    end

    for (genvar g = 0; g < 4; g++) begin : g_bank
        ier_enable_reg #(
            .IDX  (g),
            .IMPL (IMPL_MASK[g])
        ) u_bank (
            .sys_clk    (sys_clk),
            .rst        (rst),
            .regPort    (regBus.bank),
            .srcEvent   (srcWord[g]),
            .enable_ff  (enWord[g]),
            .flag_ff    (flWord[g]),
            .request_ff (reqWord[g])
        );
    end

    // Readback comes from the stored words, so unused positions read zero
    assign selWord    = regBus.rdIdx[2] ? flWord[regBus.rdIdx[1:0]] : enWord[regBus.rdIdx[1:0]];
    assign nxt_hrdata = regBus.rdMapped ? {16'h0000, selWord} : 32'h00000000;

    // One wait state on reads lets a write just before it land first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata_ff    <= 32'h00000000;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= ~regBus.rdAccept;
            if (regBus.rdPend) begin
                hrdata_ff <= nxt_hrdata;
            end
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    assign serial2TxIrqReq          = reqWord[0][`IER_SERIAL2_TX_BIT];
    assign serial2RxIrqReq          = reqWord[0][`IER_SERIAL2_RX_BIT];
    assign extPin2IrqReq            = reqWord[0][`IER_EXT_PIN2_BIT];
    assign capcmp4TimerIrqReq       = reqWord[0][`IER_CAPCMP4_TIMER_BIT];
    assign capcmp3TimerIrqReq       = reqWord[0][`IER_CAPCMP3_TIMER_BIT];
    assign capcmp5EventIrqReq       = reqWord[0][`IER_CAPCMP5_EVENT_BIT];
    assign extPin1IrqReq            = reqWord[0][`IER_EXT_PIN1_BIT];
    assign changeNotifyIrqReq       = reqWord[0][`IER_CHANGE_NOTIFY_BIT];
    assign comparatorIrqReq         = reqWord[0][`IER_COMPARATOR_BIT];
    assign syncPort1CollisionIrqReq = reqWord[0][`IER_SYNC1_COLLISION_BIT];
    assign syncPort1EventIrqReq     = reqWord[0][`IER_SYNC1_EVENT_BIT];
    assign capcmp5TimerIrqReq       = reqWord[1][`IER_CAPCMP5_TIMER_BIT];
    assign calendarClockIrqReq      = reqWord[2][`IER_CALENDAR_CLOCK_BIT];
    assign syncPort2CollisionIrqReq = reqWord[2][`IER_SYNC2_COLLISION_BIT];
    assign syncPort2EventIrqReq     = reqWord[2][`IER_SYNC2_EVENT_BIT];
    assign dacTwoIrqReq             = reqWord[3][`IER_DAC_TWO_BIT];
    assign dacOneIrqReq             = reqWord[3][`IER_DAC_ONE_BIT];
    assign chargeTimeUnitIrqReq     = reqWord[3][`IER_CHARGE_TIME_BIT];
    assign voltageDetectIrqReq      = reqWord[3][`IER_VOLTAGE_DETECT_BIT];
    assign serial2ErrorIrqReq       = reqWord[3][`IER_SERIAL2_ERROR_BIT];
    assign serial1ErrorIrqReq       = reqWord[3][`IER_SERIAL1_ERROR_BIT];
endmodule

// ### ier_enable_chk.sv
// Bus and request checks for the enable register bank
`timescale 1ns/100ps
`include "ier_consts.svh"
module ier_enable_chk (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        serial2TxIrqReq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic take;
    logic nxt_wrPh;
    logic wrPh_ff;
    assign take     = hsel && htrans[1] && hready;
    assign nxt_wrPh = take && hwrite;
    // Marks a write data phase; a request may only drop after one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPh_ff <= 1'b0;
        end else begin
            wrPh_ff <= nxt_wrPh;
        end
    end
    reset_quiet_a: assert property (disable iff (1'b0) rst && $past(rst) |-> hreadyout && hrdata == 32'h0 && !serial2TxIrqReq)
        else $error("outputs not quiet in reset");
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    unmapped_zero_a: assert property (take && !hwrite && haddr >= 32'h20 |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (hrdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    word1_unused_a: assert property (take && !hwrite && haddr == 32'h0 |=> ##1 (hrdata[15:0] & ~`IER_MASK1) == 16'h0)
        else $error("word one unused bit set");
    word2_unused_a: assert property (take && !hwrite && haddr == 32'h4 |=> ##1 (hrdata[15:0] & ~`IER_MASK2) == 16'h0)
        else $error("word two unused bit set");
    req_sticky_a: assert property (serial2TxIrqReq && !$past(wrPh_ff) |=> serial2TxIrqReq)
        else $error("request dropped without a write");
endmodule

// ### ier_src_model.sv
// Peripheral side: turns commanded pulses into source events
`timescale 1ns/100ps
module ier_src_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [20:0] fireReq,
    output logic [20:0]      srcEvt_ff
);
    // Registered so events change just after an edge, as a peripheral would
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            srcEvt_ff <= 21'h0;
        end else begin
            srcEvt_ff <= fireReq;
        end
    end
endmodule

// ### tb_interrupt_enable_regs_1_to_4.sv
// Testbench for the enable register bank
`timescale 1ns/100ps
`include "ier_consts.svh"
module tb_interrupt_enable_regs_1_to_4;
    logic               sys_clk;
    logic               rst;
    logic               hsel;
    logic               hwrite;
    logic [1:0]         htrans;
    logic [31:0]        haddr;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               rdyN;
    logic [31:0]        rdN;
    logic [31:0]        q;
    logic [20:0]        fire;
    logic [20:0]        fireV;
    logic [20:0]        ev;
    logic [20:0]        rq;
    logic [15:0]        en [4];
    int                 num_errors;
    int                 checks;
    int                 wi [21] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 2, 3, 3, 3, 3, 3, 3};
    int                 bi [21] = '{15, 14, 13, 12, 11, 6, 4, 3, 2, 1, 0, 9, 14, 2, 1, 15, 14, 13, 8, 2, 1};
    ier_pkg::ier_word_t mask [4] = '{`IER_MASK1, `IER_MASK2, `IER_MASK3, `IER_MASK4};

    ier_enable_top dut (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .serial2TxEvent(ev[0]), .serial2RxEvent(ev[1]), .extPin2Event(ev[2]),
        .capcmp4TimerEvent(ev[3]), .capcmp3TimerEvent(ev[4]), .capcmp5EventEvent(ev[5]), .extPin1Event(ev[6]),
        .changeNotifyEvent(ev[7]), .comparatorEvent(ev[8]), .syncPort1CollisionEvent(ev[9]),
        .syncPort1EventEvent(ev[10]), .capcmp5TimerEvent(ev[11]), .calendarClockEvent(ev[12]),
        .syncPort2CollisionEvent(ev[13]), .syncPort2EventEvent(ev[14]), .dacTwoEvent(ev[15]), .dacOneEvent(ev[16]),
        .chargeTimeUnitEvent(ev[17]), .voltageDetectEvent(ev[18]), .serial2ErrorEvent(ev[19]),
        .serial1ErrorEvent(ev[20]), .serial2TxIrqReq(rq[0]), .serial2RxIrqReq(rq[1]), .extPin2IrqReq(rq[2]),
        .capcmp4TimerIrqReq(rq[3]), .capcmp3TimerIrqReq(rq[4]), .capcmp5EventIrqReq(rq[5]), .extPin1IrqReq(rq[6]),
        .changeNotifyIrqReq(rq[7]), .comparatorIrqReq(rq[8]), .syncPort1CollisionIrqReq(rq[9]),
        .syncPort1EventIrqReq(rq[10]), .capcmp5TimerIrqReq(rq[11]), .calendarClockIrqReq(rq[12]),
        .syncPort2CollisionIrqReq(rq[13]), .syncPort2EventIrqReq(rq[14]), .dacTwoIrqReq(rq[15]),
        .dacOneIrqReq(rq[16]), .chargeTimeUnitIrqReq(rq[17]), .voltageDetectIrqReq(rq[18]),
        .serial2ErrorIrqReq(rq[19]), .serial1ErrorIrqReq(rq[20])
    );
    ier_src_model srcs (.sys_clk, .rst, .fireReq(fire), .srcEvt_ff(ev));

    always #5 sys_clk = ~sys_clk;
    // Registered outputs are steady at the falling edge, so no race with the rising one
    always @(negedge sys_clk) begin
        rdyN = hreadyout;
        rdN  = hrdata;
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!rdyN && n < 50);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!rdyN && n < 50);
        q = rdN;
        if (n >= 50) begin
            num_errors++;
            results();
        end
    endtask

    task automatic pulse(input logic [20:0] m);
        fire <= m;
        @(posedge sys_clk);
        fire <= 21'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    // Request is registered one cycle behind flag and enable
    task automatic expectReq(input logic [20:0] e);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check({11'h0, rq}, {11'h0, e});
        // Back on a rising edge so the next bus request starts right after it
        @(posedge sys_clk);
    endtask

    function automatic logic [20:0] expReq(input logic [20:0] f);
        for (int i = 0; i < 21; i++) begin
            expReq[i] = f[i] & en[wi[i]][bi[i]];
        end
    endfunction

    initial begin
        sys_clk    = 1'b0;
        rst        = 1'b1;
        hsel       = 1'b0;
        hwrite     = 1'b0;
        htrans     = 2'b00;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        fire       = 21'h0;
        num_errors = 0;
        checks     = 0;
        void'($urandom(32'hC136));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, 32'(4 * k), 32'h0);
            check(q, 32'h0);
        end
        $display("Reset values done");
        for (int k = 0; k < 4; k++) begin
            en[k] = 16'($urandom);
            xfer(1'b1, 32'(4 * k), 32'hFFFFFFFF);
            xfer(1'b0, 32'(4 * k), 32'h0);
            check(q, {16'h0, mask[k]});
            xfer(1'b1, 32'(4 * k), {en[k], en[k]});
            xfer(1'b0, 32'(4 * k), 32'h0);
            check(q, {16'h0, en[k] & mask[k]});
        end
        xfer(1'b1, 32'h20, 32'hFFFFFFFF);
        xfer(1'b0, 32'h20, 32'h0);
        check(q, 32'h0);
        $display("Register access done");
        for (int i = 0; i < 21; i++) begin
            for (int k = 0; k < 8; k++) begin
                xfer(1'b1, 32'(4 * k), 32'h0);
            end
            pulse(21'h1 << i);
            expectReq(21'h0);
            xfer(1'b0, 32'(16 + 4 * wi[i]), 32'h0);
            check(q, 32'h1 << bi[i]);
            xfer(1'b1, 32'(4 * wi[i]), 32'h1 << bi[i]);
            expectReq(21'h1 << i);
            xfer(1'b1, 32'(4 * wi[i]), 32'h0);
            expectReq(21'h0);
        end
        $display("Source gating done");
        for (int r = 0; r < 6; r++) begin
            for (int k = 0; k < 4; k++) begin
                en[k] = 16'($urandom);
                xfer(1'b1, 32'(4 * k), {16'h0, en[k]});
                xfer(1'b1, 32'(16 + 4 * k), 32'h0);
            end
            fireV = 21'($urandom);
            pulse(fireV);
            expectReq(expReq(fireV));
        end
        $display("Random gating done");
        // Reset in mid-run with enables and flags set must clear them all
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        expectReq(21'h0);
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, 32'(4 * k), 32'h0);
            check(q, 32'h0);
        end
        $display("Mid-run reset done");
        results();
    end
endmodule

bind ier_enable_top ier_enable_chk chk (
    .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .serial2TxIrqReq
);
